// ### logic/load_prot_pkg.sv
// constants shared by the load input protection controller
// assumes one 20 MHz system clock and a synchronous reset
package load_prot_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SET_W = 24;
	// register byte addresses
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] AMP_LIM_OFS = 8'h08;
	localparam logic [7:0] VOLT_LIM_OFS = 8'h0c;
	localparam logic [7:0] WATT_LIM_OFS = 8'h10;
	localparam logic [7:0] CUTOFF_OFS = 8'h14;
	localparam logic [7:0] AMP_SET_OFS = 8'h18;
	localparam logic [7:0] VOLT_SET_OFS = 8'h1c;
	localparam logic [7:0] RANGE_OFS = 8'h20;
	localparam logic [7:0] CMD_AMP_OFS = 8'h24;
	localparam logic [7:0] CMD_VOLT_OFS = 8'h28;
	localparam logic [7:0] CAP_OFS = 8'h2c;
	localparam logic [7:0] MEAS_V_OFS = 8'h30;
	localparam logic [7:0] MEAS_I_OFS = 8'h34;
	localparam logic [7:0] MEAS_P_OFS = 8'h38;
	// command register bits (keys: write one to act, any control write acts as the any key; rear bit and mode field are stored settings)
	localparam int unsigned CMD_TOGGLE_B = 0;
	localparam int unsigned CMD_SHORT_B = 1;
	localparam int unsigned CMD_BATT_B = 2;
	localparam int unsigned CMD_ANYKEY_B = 3;
	localparam int unsigned CMD_REAR_B = 4;
	localparam int unsigned CMD_MODE_LSB = 8;
	// short-circuit current is range * 12 / 10
	localparam logic [3:0] SHORT_NUM = 4'hc;
	localparam logic [3:0] SHORT_DEN = 4'ha;
	// resolution thresholds in setting units (mV, mA)
	localparam logic [23:0] FINE_VOLT_MV = 24'h004e20;
	localparam logic [23:0] FINE_AMP_MA = 24'h000bb8;
	localparam logic [7:0] THERMAL_C = 8'h50;
	localparam logic [2:0] BLANK_MSG = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		MODE_AMP = 2'h0,
		MODE_VOLT = 2'h1,
		MODE_WATT = 2'h2,
		MODE_OHM = 2'h3
	} reg_mode_t;
	typedef enum logic [2:0] {
		MSG_NONE = 3'h0,
		MSG_THERMAL = 3'h1,
		MSG_VOLT = 3'h2,
		MSG_WATT = 3'h3,
		MSG_AMP = 3'h4,
		MSG_REVERSE = 3'h5
	} msg_t;
endpackage

// ### logic/load_input_protection_ctrl.sv
// supervisory control of the load input: enable, short, trips, sense, battery test
// assumes comparator flags and measurements from the analog front end, AXI4-Lite master
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Function
// - short toggle keeps setpoint, exit restores settings
// - short in amp/watt/ohm: 1.2x range current
// - short in volt mode: zero volt setpoint
// - toggle key inverts enable, indicator follows
// - overvoltage disables input, buzzer, message
// - voltage fine resolution below 20 V
// - overcurrent sounds buzzer, shows message
// - current fine resolution at or below 3 A
// - overpower latches message until any key
// - disabled input stays off after acknowledge
// - persisting overpower trips again
// - reversed polarity buzzer and message
// - over 80 C disables input
// - three user limits set trip thresholds
// - exactly one sense path active
// - battery test stops at cutoff voltage
// - toggle key starts/pauses battery discharge
// - battery key again exits battery mode
// - battery figures available for display
module load_input_protection_ctrl #(
	parameter int unsigned CAP_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [23:0] meas_volt,
	input wire logic [23:0] meas_amp,
	input wire logic [23:0] meas_watt,
	input wire logic [7:0] temp_c,
	input wire logic reverse_det,
	input wire logic cap_tick,
	output logic input_on,
	output logic [1:0] reg_mode,
	output logic [23:0] cmd_amp,
	output logic [23:0] cmd_volt,
	output logic front_sense_en,
	output logic rear_sense_en,
	output logic volt_fine_res,
	output logic amp_fine_res,
	output logic buzzer,
	output logic [2:0] msg_code,
	output logic battery_mode
);
	logic aw_hold_r, w_hold_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [23:0] amp_lim_r, volt_lim_r, watt_lim_r, cutoff_r, amp_set_r, volt_set_r, range_r;
	logic [1:0] mode_r;
	logic rear_r, enable_r, short_r, batt_r, run_r;
	logic volt_trip_r, amp_trip_r, watt_trip_r, thermal_trip_r, rev_r;
	logic [CAP_W-1:0] cap_r;
	logic [23:0] mv_r, mi_r, mp_r;
	logic [7:0] mt_r;
	logic [2:0] rev_sync_r;
	logic [7:0] cmd_r;
	logic wr_go, wr_cmd, rd_go;
	logic k_toggle, k_short, k_batt, k_any;
	logic over_v, over_i, over_p, over_t, at_cutoff;
	logic [27:0] short_prod;
	logic [2:0] msg_nxt;

	// write takes address and data in either order, answers once both are held
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_cmd = wr_go && awaddr_r == load_prot_pkg::CTRL_OFS && wstrb_r[0];
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign rd_go = s_axi_arvalid && !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// key strobes decoded from the command word
	assign k_toggle = wr_cmd && wdata_r[load_prot_pkg::CMD_TOGGLE_B];
	assign k_short = wr_cmd && wdata_r[load_prot_pkg::CMD_SHORT_B];
	assign k_batt = wr_cmd && wdata_r[load_prot_pkg::CMD_BATT_B];
	assign k_any = wr_cmd;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = a[1:0] == 2'h0 && a <= load_prot_pkg::MEAS_P_OFS;
	endfunction

	// write channel capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= load_prot_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= known_addr(awaddr_r) ? load_prot_pkg::RESP_OKAY : load_prot_pkg::RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// settings registers, full-word writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			amp_lim_r <= 24'h000000;
			volt_lim_r <= 24'h000000;
			watt_lim_r <= 24'h000000;
			cutoff_r <= 24'h000000;
			amp_set_r <= 24'h000000;
			volt_set_r <= 24'h000000;
			range_r <= 24'h000000;
			mode_r <= load_prot_pkg::MODE_AMP;
			rear_r <= 1'b0;
		end
		else if (wr_go && wstrb_r == 4'hf)
		begin
			unique case (awaddr_r)
				load_prot_pkg::AMP_LIM_OFS: amp_lim_r <= wdata_r[23:0];
				load_prot_pkg::VOLT_LIM_OFS: volt_lim_r <= wdata_r[23:0];
				load_prot_pkg::WATT_LIM_OFS: watt_lim_r <= wdata_r[23:0];
				load_prot_pkg::CUTOFF_OFS: cutoff_r <= wdata_r[23:0];
				load_prot_pkg::AMP_SET_OFS: amp_set_r <= wdata_r[23:0];
				load_prot_pkg::VOLT_SET_OFS: volt_set_r <= wdata_r[23:0];
				load_prot_pkg::RANGE_OFS: range_r <= wdata_r[23:0];
				load_prot_pkg::CTRL_OFS:
				begin
					if (!batt_r)
						mode_r <= wdata_r[load_prot_pkg::CMD_MODE_LSB +: 2];
					rear_r <= wdata_r[load_prot_pkg::CMD_REAR_B];
				end
				default: ;
			endcase
		end
	end

	// measured values sampled once on the clock; reversal pin passes four flops
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mv_r <= 24'h000000;
			mi_r <= 24'h000000;
			mp_r <= 24'h000000;
			mt_r <= 8'h00;
			rev_r <= 1'b0;
			rev_sync_r <= 3'h0;
		end
		else
		begin
			mv_r <= meas_volt;
			mi_r <= meas_amp;
			mp_r <= meas_watt;
			mt_r <= temp_c;
			rev_sync_r <= {rev_sync_r[1:0], reverse_det};
			if (rev_sync_r[1] == rev_sync_r[2])
				rev_r <= rev_sync_r[2]; // only a settled level counts
		end
	end

	// limit comparators
	assign over_v = mv_r > volt_lim_r;
	assign over_i = mi_r > amp_lim_r;
	assign over_p = mp_r > watt_lim_r;
	assign over_t = mt_r > load_prot_pkg::THERMAL_C;
	assign at_cutoff = batt_r && run_r && mv_r <= cutoff_r;

	// trip latches: a key clears, a still-present condition sets again
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			volt_trip_r <= 1'b0;
			amp_trip_r <= 1'b0;
			watt_trip_r <= 1'b0;
			thermal_trip_r <= 1'b0;
		end
		else
		begin
			volt_trip_r <= over_v || (volt_trip_r && !k_any);
			amp_trip_r <= over_i || (amp_trip_r && !k_any);
			watt_trip_r <= over_p || (watt_trip_r && !k_any);
			thermal_trip_r <= over_t || (thermal_trip_r && !k_any);
		end
	end

	// input enable, short and battery state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enable_r <= 1'b0;
			short_r <= 1'b0;
			batt_r <= 1'b0;
			run_r <= 1'b0;
		end
		else
		begin
			if (over_v || over_t || at_cutoff)
			begin
				enable_r <= 1'b0;
				run_r <= 1'b0;
			end
			else if (k_toggle)
			begin
				enable_r <= !enable_r;
				if (batt_r)
					run_r <= !run_r;
			end
			if (k_short)
				short_r <= !short_r;
			if (k_batt)
			begin
				batt_r <= !batt_r;
				run_r <= 1'b0;
			end
		end
	end

	// discharged capacity accumulates while the test runs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cap_r <= '0;
		else if (k_batt && !batt_r)
			cap_r <= '0;
		else if (run_r && enable_r && cap_tick)
			cap_r <= cap_r + CAP_W'(mi_r);
	end

	// short commands: setpoints left alone, only the outputs change
	assign short_prod = range_r * load_prot_pkg::SHORT_NUM;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_amp <= 24'h000000;
			cmd_volt <= 24'h000000;
		end
		else if (short_r && mode_r != load_prot_pkg::MODE_VOLT)
		begin
			cmd_amp <= 24'(short_prod / load_prot_pkg::SHORT_DEN);
			cmd_volt <= volt_set_r;
		end
		else if (short_r)
		begin
			cmd_amp <= amp_set_r;
			cmd_volt <= 24'h000000;
		end
		else
		begin
			cmd_amp <= amp_set_r;
			cmd_volt <= volt_set_r;
		end
	end

	// message priority: disabling trips first
	always_comb
	begin
		if (thermal_trip_r)
			msg_nxt = load_prot_pkg::MSG_THERMAL;
		else if (volt_trip_r)
			msg_nxt = load_prot_pkg::MSG_VOLT;
		else if (watt_trip_r)
			msg_nxt = load_prot_pkg::MSG_WATT;
		else if (amp_trip_r)
			msg_nxt = load_prot_pkg::MSG_AMP;
		else if (rev_r)
			msg_nxt = load_prot_pkg::MSG_REVERSE;
		else
			msg_nxt = load_prot_pkg::BLANK_MSG;
	end

	// status outputs from flip-flops
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			msg_code <= load_prot_pkg::BLANK_MSG;
			buzzer <= 1'b0;
			input_on <= 1'b0;
			reg_mode <= load_prot_pkg::MODE_AMP;
			front_sense_en <= 1'b1;
			rear_sense_en <= 1'b0;
			volt_fine_res <= 1'b1;
			amp_fine_res <= 1'b1;
			battery_mode <= 1'b0;
		end
		else
		begin
			msg_code <= msg_nxt;
			buzzer <= msg_nxt != load_prot_pkg::BLANK_MSG;
			input_on <= enable_r;
			reg_mode <= batt_r ? load_prot_pkg::MODE_AMP : mode_r;
			front_sense_en <= !rear_r;
			rear_sense_en <= rear_r;
			volt_fine_res <= volt_lim_r < load_prot_pkg::FINE_VOLT_MV;
			amp_fine_res <= amp_lim_r <= load_prot_pkg::FINE_AMP_MA;
			battery_mode <= batt_r;
		end
	end

	// read mux
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= load_prot_pkg::RESP_OKAY;
		end
		else if (rd_go)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= known_addr(s_axi_araddr) ? load_prot_pkg::RESP_OKAY : load_prot_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				load_prot_pkg::CTRL_OFS: rdata_r <= {22'h0, mode_r, 3'h0, rear_r, 4'h0};
				load_prot_pkg::STATUS_OFS: rdata_r <= {20'h0, msg_nxt, rev_r, thermal_trip_r, watt_trip_r,
					amp_trip_r, volt_trip_r, run_r, batt_r, short_r, enable_r};
				load_prot_pkg::AMP_LIM_OFS: rdata_r <= {8'h00, amp_lim_r};
				load_prot_pkg::VOLT_LIM_OFS: rdata_r <= {8'h00, volt_lim_r};
				load_prot_pkg::WATT_LIM_OFS: rdata_r <= {8'h00, watt_lim_r};
				load_prot_pkg::CUTOFF_OFS: rdata_r <= {8'h00, cutoff_r};
				load_prot_pkg::AMP_SET_OFS: rdata_r <= {8'h00, amp_set_r};
				load_prot_pkg::VOLT_SET_OFS: rdata_r <= {8'h00, volt_set_r};
				load_prot_pkg::RANGE_OFS: rdata_r <= {8'h00, range_r};
				load_prot_pkg::CMD_AMP_OFS: rdata_r <= {8'h00, cmd_amp};
				load_prot_pkg::CMD_VOLT_OFS: rdata_r <= {8'h00, cmd_volt};
				load_prot_pkg::CAP_OFS: rdata_r <= 32'(cap_r);
				load_prot_pkg::MEAS_V_OFS: rdata_r <= {8'h00, mv_r};
				load_prot_pkg::MEAS_I_OFS: rdata_r <= {8'h00, mi_r};
				load_prot_pkg::MEAS_P_OFS: rdata_r <= {8'h00, mp_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// checks
	a_volt_disable: assert property (@(posedge aclk) disable iff (!aresetn) over_v |=> !enable_r)
		else $error("input stays on after overvoltage");
	a_thermal_off: assert property (@(posedge aclk) disable iff (!aresetn) over_t |=> ##1 !input_on)
		else $error("input on while overheated");
	a_sense_onehot: assert property (@(posedge aclk) disable iff (!aresetn) front_sense_en != rear_sense_en)
		else $error("sense paths not exclusive");
	a_watt_retrip: assert property (@(posedge aclk) disable iff (!aresetn) over_p |=> watt_trip_r)
		else $error("overpower not latched");
	a_watt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		watt_trip_r && !k_any && !over_p |=> watt_trip_r)
		else $error("overpower cleared without a key");
	a_short_volt: assert property (@(posedge aclk) disable iff (!aresetn)
		short_r && mode_r == load_prot_pkg::MODE_VOLT |=> cmd_volt == 24'h000000)
		else $error("short in volt mode not zero");
	a_short_keep: assert property (@(posedge aclk) disable iff (!aresetn) k_short |=> $stable(amp_set_r))
		else $error("short changed the setpoint");
	a_cutoff_stop: assert property (@(posedge aclk) disable iff (!aresetn) at_cutoff |=> !run_r && !enable_r)
		else $error("battery test did not stop at cutoff");
	a_toggle_flip: assert property (@(posedge aclk) disable iff (!aresetn)
		k_toggle && !over_v && !over_t && !at_cutoff |=> enable_r != $past(enable_r))
		else $error("toggle did not invert enable");
	a_buzz_msg: assert property (@(posedge aclk) disable iff (!aresetn) rev_r |=> buzzer)
		else $error("no buzzer on reversal");
	c_short: cover property (@(posedge aclk) disable iff (!aresetn) k_short ##1 short_r);
	c_batt_run: cover property (@(posedge aclk) disable iff (!aresetn) run_r ##[1:100] !run_r);
	c_watt_ack: cover property (@(posedge aclk) disable iff (!aresetn) watt_trip_r ##1 !watt_trip_r);
endmodule

`default_nettype wire

// ### tb/source_model.sv
// partner model: the source or battery under test on the load input
// assumes the bench sets source levels; drawn current follows the command while enabled
`timescale 1ns/1ps
`default_nettype none
module source_model (
	input wire logic aclk,
	input wire logic input_on,
	input wire logic [23:0] cmd_amp,
	input wire logic [23:0] src_volt,
	input wire logic [23:0] src_watt,
	output logic [23:0] meas_volt,
	output logic [23:0] meas_amp,
	output logic [23:0] meas_watt,
	output logic cap_tick
);
	logic [2:0] tick_r = 3'h0;
	// a disabled load draws no current and no power
	assign meas_volt = src_volt;
	assign meas_amp = input_on ? cmd_amp : 24'h000000;
	assign meas_watt = input_on ? src_watt : 24'h000000;
	// capacity sample pulse every eight clocks
	always_ff @(posedge aclk)
	begin
		tick_r <= tick_r + 3'h1;
	end
	assign cap_tick = (tick_r == 3'h7);
endmodule
`default_nettype wire

// ### tb/load_input_protection_ctrl_tb.sv
// self-checking bench for the load input protection controller
// assumes an AXI4-Lite slave that answers within a few cycles and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module load_input_protection_ctrl_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic awready, wready, bvalid, arready, rvalid, cap_tick, input_on, front_sense_en, rear_sense_en;
	logic [1:0] bresp, rresp, rsp, reg_mode;
	logic [23:0] src_volt = 24'h0, src_watt = 24'h0, meas_volt, meas_amp, meas_watt, cmd_amp, cmd_volt;
	logic [7:0] temp_c = 8'h19;
	logic reverse_det = 1'b0, volt_fine_res, amp_fine_res, buzzer, battery_mode;
	logic [3:0] wstrb = 4'hf;
	logic [2:0] msg_code;
	int fail_count = 0, samples_checked = 0, cycles = 0;
	typedef struct {logic [7:0] a; logic [31:0] d; logic vf; logic af;} row_t;
	row_t rows [11] = '{'{load_prot_pkg::VOLT_LIM_OFS, 32'h4e1f, 1'b1, 1'b1},
		'{load_prot_pkg::VOLT_LIM_OFS, 32'h4e21, 1'b0, 1'b1}, '{load_prot_pkg::AMP_LIM_OFS, 32'hbb8, 1'b0, 1'b1},
		'{load_prot_pkg::AMP_LIM_OFS, 32'hbb9, 1'b0, 1'b0}, '{load_prot_pkg::VOLT_LIM_OFS, 32'hffffff, 1'b0, 1'b0},
		'{load_prot_pkg::AMP_LIM_OFS, 32'hffffff, 1'b0, 1'b0}, '{load_prot_pkg::WATT_LIM_OFS, 32'hffffff, 1'b0, 1'b0},
		'{load_prot_pkg::AMP_SET_OFS, 32'h64, 1'b0, 1'b0}, '{load_prot_pkg::VOLT_SET_OFS, 32'h1388, 1'b0, 1'b0},
		'{load_prot_pkg::RANGE_OFS, 32'h3e8, 1'b0, 1'b0}, '{load_prot_pkg::CUTOFF_OFS, 32'h2710, 1'b0, 1'b0}};
	load_input_protection_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .meas_volt(meas_volt), .meas_amp(meas_amp),
		.meas_watt(meas_watt), .temp_c(temp_c), .reverse_det(reverse_det), .cap_tick(cap_tick),
		.input_on(input_on), .reg_mode(reg_mode), .cmd_amp(cmd_amp), .cmd_volt(cmd_volt),
		.front_sense_en(front_sense_en), .rear_sense_en(rear_sense_en), .volt_fine_res(volt_fine_res),
		.amp_fine_res(amp_fine_res), .buzzer(buzzer), .msg_code(msg_code), .battery_mode(battery_mode));
	source_model partner (.aclk(aclk), .input_on(input_on), .cmd_amp(cmd_amp), .src_volt(src_volt),
		.src_watt(src_watt), .meas_volt(meas_volt), .meas_amp(meas_amp), .meas_watt(meas_watt), .cap_tick(cap_tick));
	// clock and hang guard
	always #25 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle();
		repeat (4) @(posedge aclk);
		@(negedge aclk);
	endtask
	// handshakes are sampled at the falling edge, released after the rising edge that takes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tr;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tr = 1'b0;
		while (!tr)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = bvalid && bready;
			rsp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) bready <= 1'b0;
		end
		settle();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			d = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
	endtask
	task automatic ctl(input logic [1:0] m, input logic r, input logic [3:0] k);
		wr(load_prot_pkg::CTRL_OFS, {22'h0, m, 3'h0, r, k});
	endtask
	task automatic src(input logic [23:0] v, input logic [23:0] w, input logic [7:0] t, input logic rev);
		@(posedge aclk);
		src_volt <= v;
		src_watt <= w;
		temp_c <= t;
		reverse_det <= rev;
		settle();
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			chk(rsp, load_prot_pkg::RESP_OKAY);
			rd(rows[i].a, q);
			chk(q, rows[i].d);
			chk(volt_fine_res, rows[i].vf);
			chk(amp_fine_res, rows[i].af);
		end
		$display("test settings done");
		ctl(2'h0, 1'b0, 4'h1);
		chk(input_on, 1);
		rd(load_prot_pkg::STATUS_OFS, q);
		chk(q[0], 1);
		for (int m = 0; m < 4; m++)
		begin
			ctl(m[1:0], 1'b0, 4'h0);
			ctl(m[1:0], 1'b0, 4'h2);
			chk(m == 1 ? cmd_volt : cmd_amp, m == 1 ? 32'h0 : 32'h4b0);
			rd(load_prot_pkg::AMP_SET_OFS, q);
			chk(q, 32'h64);
			ctl(m[1:0], 1'b0, 4'h2);
			chk(m == 1 ? cmd_volt : cmd_amp, m == 1 ? 32'h1388 : 32'h64);
		end
		$display("test short done");
		ctl(2'h0, 1'b1, 4'h0);
		chk({front_sense_en, rear_sense_en}, 2'b01);
		ctl(2'h0, 1'b0, 4'h0);
		chk({front_sense_en, rear_sense_en}, 2'b10);
		wr(load_prot_pkg::AMP_LIM_OFS, 32'h32);
		chk({buzzer, msg_code}, {1'b1, load_prot_pkg::MSG_AMP});
		wr(load_prot_pkg::AMP_LIM_OFS, 32'hffffff);
		wr(load_prot_pkg::WATT_LIM_OFS, 32'h100);
		src(24'h0, 24'h200, 8'h19, 1'b0);
		chk({input_on, buzzer, msg_code}, {2'b11, load_prot_pkg::MSG_WATT});
		ctl(2'h0, 1'b0, 4'h8);
		chk(msg_code, load_prot_pkg::MSG_WATT);
		src(24'h0, 24'h0, 8'h19, 1'b0);
		ctl(2'h0, 1'b0, 4'h8);
		chk({input_on, msg_code}, {1'b1, load_prot_pkg::MSG_NONE});
		src(24'h0, 24'h200, 8'h19, 1'b0);
		ctl(2'h0, 1'b0, 4'h1);
		chk(msg_code, load_prot_pkg::MSG_WATT);
		ctl(2'h0, 1'b0, 4'h8);
		chk({input_on, msg_code}, {1'b0, load_prot_pkg::MSG_NONE});
		wr(load_prot_pkg::WATT_LIM_OFS, 32'hffffff);
		$display("test current and power trips done");
		wr(load_prot_pkg::VOLT_LIM_OFS, 32'h3e8);
		src(24'h3e9, 24'h0, 8'h19, 1'b0);
		chk({input_on, buzzer, msg_code}, {2'b01, load_prot_pkg::MSG_VOLT});
		src(24'h3e8, 24'h0, 8'h19, 1'b0);
		ctl(2'h0, 1'b0, 4'h8);
		chk({input_on, msg_code}, {1'b0, load_prot_pkg::MSG_NONE});
		wr(load_prot_pkg::VOLT_LIM_OFS, 32'hffffff);
		src(24'h3e8, 24'h0, 8'h50, 1'b0);
		ctl(2'h0, 1'b0, 4'h1);
		chk({input_on, msg_code}, {1'b1, load_prot_pkg::MSG_NONE});
		src(24'h3e8, 24'h0, 8'h51, 1'b1);
		chk({input_on, buzzer, msg_code}, {2'b01, load_prot_pkg::MSG_THERMAL});
		src(24'h3e8, 24'h0, 8'h19, 1'b1);
		ctl(2'h0, 1'b0, 4'h8);
		chk({buzzer, msg_code}, {1'b1, load_prot_pkg::MSG_REVERSE});
		src(24'h3000, 24'h0, 8'h19, 1'b0);
		ctl(2'h0, 1'b0, 4'h8);
		chk({buzzer, msg_code}, 4'h0);
		$display("test voltage, thermal and polarity done");
		ctl(2'h0, 1'b0, 4'h4);
		ctl(2'h2, 1'b0, 4'h0);
		chk({battery_mode, reg_mode}, 3'b100);
		rd(load_prot_pkg::CTRL_OFS, q);
		chk(q[9:8], 2'h0);
		ctl(2'h0, 1'b0, 4'h1);
		chk(input_on, 1);
		rd(load_prot_pkg::MEAS_V_OFS, q);
		chk(q, 32'h3000);
		ctl(2'h0, 1'b0, 4'h1);
		chk(input_on, 0);
		ctl(2'h0, 1'b0, 4'h1);
		src(24'h2710, 24'h0, 8'h19, 1'b0);
		chk(input_on, 0);
		rd(load_prot_pkg::CAP_OFS, q);
		chk(q != 32'h0 && q % 32'h64 == 32'h0, 1'b1);
		ctl(2'h0, 1'b0, 4'h4);
		chk(battery_mode, 0);
		$display("test battery done");
		rd(8'h3c, q);
		chk(q, 32'h0);
		chk(rsp, load_prot_pkg::RESP_SLVERR);
		wr(8'h3c, 32'h1);
		chk(rsp, load_prot_pkg::RESP_SLVERR);
		@(posedge aclk);
		wstrb <= 4'h1;
		wr(load_prot_pkg::AMP_LIM_OFS, 32'h1);
		@(posedge aclk);
		wstrb <= 4'hf;
		rd(load_prot_pkg::AMP_LIM_OFS, q);
		chk(q, 32'hffffff);
		ctl(2'h0, 1'b1, 4'h1);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({input_on, front_sense_en, rear_sense_en, buzzer, msg_code, battery_mode, volt_fine_res, amp_fine_res},
			{4'b0100, 3'h0, 3'b011});
		$display("test unmapped and reset done");
		conclude();
	end
endmodule
`default_nettype wire
